// ===== verif/slem_error_monitor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module slem_error_monitor_tb;
   logic ref_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, cfg_bad = 0, irq_n, sync;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, rv, fire_lanes = 8'h00, len;
   slem_pkg::slem_lane_err_t fire_kind = 3'h0;
   slem_pkg::slem_lane_err_t [7:0] lane_err;
   logic [111:0] rx_cfg, tx_cfg = {14{8'h5a}};
   int n_errors = 0, n_checks = 0;
   always #20 ref_clk = ~ref_clk;
   slem_tx_model u_tx (.ref_clk(ref_clk), .fire_lanes(fire_lanes), .fire_kind(fire_kind),
      .cfg_bad(cfg_bad), .tx_cfg(tx_cfg), .lane_err(lane_err), .rx_link_cfg(rx_cfg));
   slem_error_monitor dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .lane_err(lane_err), .rx_link_cfg(rx_cfg), .tx_link_cfg(tx_cfg), .irq_n(irq_n),
      .sync_request_out(sync), .lane_enable_bits(len));
   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Register bus: one strobe cycle each, data the cycle after a read
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge ref_clk) reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge ref_clk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge ref_clk) reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask
   task automatic fire(input logic [7:0] l, input logic [2:0] k, input int n);
      @(posedge ref_clk) {fire_lanes, fire_kind} <= {l, k};
      repeat (n) @(posedge ref_clk);
      fire_lanes <= 8'h00;
   endtask
   task automatic wait_sync();
      int i;
      for (i = 0; i < 10 && sync !== 1'b1; i++) @(posedge ref_clk) #1;
      if (i == 10) begin
         n_errors++;
         end_sim();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset_map();
      chk({6'h0, irq_n, sync}, 8'h02);
      chk(len, 8'hff);
      rd(12'h47b); chk(rv, 8'h08);
      rd(12'h47a); chk(rv, 8'h00);
      wr(12'h47c, 8'ha5); rd(12'h47c); chk(rv, 8'ha5);
      rd(12'h400); chk(rv, 8'h00);
   endtask
   // Each kind on its own lane, threshold 2, irq and sync both armed
   task automatic t_kinds();
      for (int k = 0; k < 3; k++) begin
         wr(12'h47c, 8'h02);
         wr(12'h47a, 8'h80 >> k);
         wr(12'h47b, 8'h08 | (8'h80 >> k));
         fire(8'h02 << k, 3'h4 >> k, 2);
         wait_sync(); chk({7'h0, sync}, 8'h01);
         chk({7'h0, irq_n}, 8'h00);
         rd(12'h46d + 12'(k)); chk(rv, 8'h02 << k);
         rd(12'h47a); chk(rv, 8'h80 >> k);
         wr(12'h47b, 8'h08); wr(12'h47a, 8'h00);
         wr(12'h47d, 8'h00); wr(12'h47d, 8'hff); rd(12'h47a);
         rd(12'h47a); chk(rv, 8'h00);
         chk({6'h0, irq_n, sync}, 8'h02);
      end
   endtask
   task automatic t_lane_off();
      wr(12'h47d, 8'hfe); wr(12'h47c, 8'h01); wr(12'h47b, 8'he8); wr(12'h47a, 8'he0);
      fire(8'h01, 3'h7, 2);
      repeat (3) @(posedge ref_clk) #1;
      chk({6'h0, irq_n, sync}, 8'h02);
      chk(len, 8'hfe);
      rd(12'h46d); chk(rv, 8'h00);
      wr(12'h47b, 8'h08); wr(12'h47a, 8'h00); wr(12'h47d, 8'hff);
   endtask
   task automatic t_mismatch();
      @(posedge ref_clk) cfg_bad <= 1'b1;
      repeat (3) @(posedge ref_clk) #1;
      chk({7'h0, irq_n}, 8'h00);
      @(posedge ref_clk) cfg_bad <= 1'b0;
      rd(12'h47b); chk(rv, 8'h18);
      // Writing a zero to the flag bit must leave it latched
      wr(12'h47b, 8'h08); rd(12'h47b); chk(rv, 8'h18);
      chk({7'h0, irq_n}, 8'h00);
      wr(12'h47b, 8'h18); rd(12'h47b); chk(rv, 8'h08);
      chk({7'h0, irq_n}, 8'h01);
      wr(12'h47b, 8'h00);
      @(posedge ref_clk) cfg_bad <= 1'b1;
      repeat (3) @(posedge ref_clk) #1;
      chk({7'h0, irq_n}, 8'h01);
      rd(12'h47b); chk(rv, 8'h00);
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      wr(12'h47d, 8'hff);
      t_reset_map();
      t_kinds();
      t_lane_off();
      t_mismatch();
      end_sim();
   end
endmodule // slem_error_monitor_tb
bind slem_error_monitor slem_monitor #(.LANES(LANES), .CFG_BITS(CFG_BITS)) u_mon (
   .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lane_err(lane_err),
   .rx_link_cfg(rx_link_cfg), .tx_link_cfg(tx_link_cfg), .irq_n(irq_n),
   .sync_request_out(sync_request_out), .lane_enable_bits(lane_enable_bits));
`default_nettype wire

// ===== verif/slem_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "slem_params.svh"
module slem_monitor #(
   parameter int LANES    = 8,
   parameter int CFG_BITS = 112
) (
   // Clock and reset
   input wire logic                                 ref_clk,
   input wire logic                                 nrst,
   // Register port
   input wire logic [`SLEM_ADDR_W-1:0]              reg_addr,
   input wire logic [7:0]                           reg_wdata,
   input wire logic                                 reg_wr,
   input wire logic                                 reg_rd,
   input wire logic [7:0]                           reg_rdata,
   // Link side
   input wire slem_pkg::slem_lane_err_t [LANES-1:0] lane_err,
   input wire logic [CFG_BITS-1:0]                  rx_link_cfg,
   input wire logic [CFG_BITS-1:0]                  tx_link_cfg,
   input wire logic                                 irq_n,
   input wire logic                                 sync_request_out,
   input wire logic [LANES-1:0]                     lane_enable_bits
);
   logic [2:0]       sel_q;
   logic [2:0]       mask_q;
   logic             cmm_en_q;
   logic [7:0]       thr_q;
   logic [LANES-1:0] ev_d, ev_n, ev_u;
   wire              mism = rx_link_cfg != tx_link_cfg;
   ////////////////////////////////////////////////////////////////////////
   // Events on enabled lanes only, so disabled lanes never arm a check
   always_comb begin
      for (int l = 0; l < LANES; l++) begin
         ev_d[l] = lane_err[l].disp & lane_enable_bits[l];
         ev_n[l] = lane_err[l].nit & lane_enable_bits[l];
         ev_u[l] = lane_err[l].ucc & lane_enable_bits[l];
      end
   end
   // Shadow of the control registers, taken from the write strobes
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sel_q <= 3'h0;
         mask_q <= 3'h0;
         cmm_en_q <= 1'b1;
         thr_q <= 8'hff;
      end else if (reg_wr) begin
         if (reg_addr == `SLEM_ADDR_SYNC_SEL) sel_q <= reg_wdata[7:5];
         if (reg_addr == `SLEM_ADDR_SYNC_SEL) cmm_en_q <= reg_wdata[3];
         if (reg_addr == `SLEM_ADDR_IRQ_VECTOR) mask_q <= reg_wdata[7:5];
         if (reg_addr == `SLEM_ADDR_THRESHOLD) thr_q <= reg_wdata;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not idle");
   a_lane_en_copy: assert property ($past(reg_wr && reg_addr == `SLEM_ADDR_LANE_EN)
      |-> lane_enable_bits == $past(reg_wdata[LANES-1:0])) else $error("lane enables not copied");
   a_lane_en_read: assert property (reg_rd && reg_addr == `SLEM_ADDR_LANE_EN
      |=> reg_rdata[LANES-1:0] == $past(lane_enable_bits)) else $error("lane enable readback");
   a_sync_needs_sel: assert property (sel_q == 3'h0 && $past(sel_q) == 3'h0
      |-> !sync_request_out) else $error("sync without select");
   a_disp_sync: assert property (sel_q[2] && thr_q == 8'h02 && |(ev_d & $past(ev_d))
      |-> ##2 sync_request_out) else $error("disparity sync missing");
   a_nit_sync: assert property (sel_q[1] && thr_q == 8'h02 && |(ev_n & $past(ev_n))
      |-> ##2 sync_request_out) else $error("invalid code sync missing");
   a_ucc_sync: assert property (sel_q[0] && thr_q == 8'h02 && |(ev_u & $past(ev_u))
      |-> ##2 sync_request_out) else $error("control char sync missing");
   a_cmm_irq_low: assert property (cmm_en_q && mism && !$past(mism) |-> ##1 !irq_n)
      else $error("mismatch irq missing");
   a_cmm_off_quiet: assert property (!cmm_en_q && !$past(cmm_en_q) && mask_q == 3'h0
      && $past(mask_q) == 3'h0 |-> irq_n) else $error("irq while disabled");
   c_sync: cover property ($rose(sync_request_out));
   c_irq: cover property ($fell(irq_n));
   c_mism: cover property (cmm_en_q && $rose(mism));
endmodule // slem_monitor
`default_nettype wire

// ===== verif/slem_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
// Transmitter side: error events per lane and lane 0 link configuration
module slem_tx_model (
   // Clock
   input  wire logic                         ref_clk,
   // Commands from the bench
   input  wire logic [7:0]                   fire_lanes,
   input  wire slem_pkg::slem_lane_err_t     fire_kind,
   input  wire logic                         cfg_bad,
   input  wire logic [111:0]                 tx_cfg,
   // Toward the monitor
   output var slem_pkg::slem_lane_err_t [7:0] lane_err,
   output logic [111:0]                      rx_link_cfg
);
   // The fire_kind events every cycle on each fired lane, registered like a real decoder
   always_ff @(posedge ref_clk) begin
      for (int l = 0; l < 8; l++) begin
         lane_err[l] <= fire_lanes[l] ? fire_kind : 3'h0;
      end
   end
   // A corrupted link configuration flips every bit, not just one
   assign rx_link_cfg = cfg_bad ? ~tx_cfg : tx_cfg;
endmodule // slem_tx_model
`default_nettype wire

// ===== verilog/slem_error_monitor.sv
// Summary of operation
// R1: With the disparity sync select set, a lane's disparity count at threshold raises the sync request.
// R2: With the invalid-code sync select set, a lane's invalid-code count at threshold raises the sync request.
// R3: With the unexpected-control sync select set, a lane's control-character count at threshold raises sync.
// R4: With mismatch interrupts enabled, a rising mismatch latches the mismatch flag and pulls irq_n low.
// R5: A latched mismatch flag clears only by software writing a one to it; the code also clears it whenever the mismatch enable is zero.
// R6: With the mismatch enable at zero the mismatch flag neither latches nor touches the interrupt.
// R7: A mismatch is seen whenever lane 0 received configuration differs from local transmit settings.
// R8: The mismatch interrupt enable resets to one.
// R9: Each lane counts the three error kinds and compares each count with an 8-bit threshold.
// R10: A count at threshold raises the interrupt, the sync request or both, per mask and select bits.
// R11: Counting and comparison run independently in every lane.
// R12: Each lane enable bit enables the lane of the same index.
// R13: Software programs the lane enables before lanes receive the code group pattern.
// R14: The three sync select bits reset to zero.
// R15: A set interrupt mask bit with its count at threshold on any lane pulls irq_n low.
// R16: A flag per error kind shows a lane at threshold and per-lane registers show which lanes.
// R17: A disabled lane neither counts nor adds to interrupt or sync generation.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "slem_params.svh"

module slem_error_monitor #(
   parameter int LANES    = 8,
   parameter int CFG_BITS = `SLEM_CFG_BYTES * 8
) (
   // Clock and reset
   input  wire logic                                ref_clk,
   input  wire logic                                nrst,
   // Register port
   input  wire logic [`SLEM_ADDR_W-1:0]             reg_addr,
   input  wire logic [7:0]                          reg_wdata,
   input  wire logic                                reg_wr,
   input  wire logic                                reg_rd,
   output logic      [7:0]                          reg_rdata,
   // Error events from the lane decoders, same clock
   input  wire slem_pkg::slem_lane_err_t [LANES-1:0] lane_err,
   // Lane 0 received link configuration and local transmit settings
   input  wire logic [CFG_BITS-1:0]                 rx_link_cfg,
   input  wire logic [CFG_BITS-1:0]                 tx_link_cfg,
   // Outputs toward the system and the transmitter
   output logic                                     irq_n,
   output logic                                     sync_request_out,
   output logic      [LANES-1:0]                    lane_enable_bits
);

   ////////////////////////////////////////////////////////////////////////////
   // Software visible state
   logic [2:0]       sync_sel;
   logic [2:0]       next_sync_sel;
   logic             cmm_en;
   logic             next_cmm_en;
   logic             cmm_flag;
   logic             next_cmm_flag;
   logic [7:0]       threshold;
   logic [7:0]       next_threshold;
   logic [2:0]       irq_mask;
   logic [2:0]       next_irq_mask;
   logic [2:0]       irq_flag;
   logic [2:0]       next_irq_flag;
   logic [LANES-1:0] next_lane_en;

   // Link state and output registers
   logic             mism_q;
   logic             next_mism_q;
   logic             next_irq_n;
   logic             next_sync;
   logic [7:0]       next_rdata;

   // Per-lane threshold hits, one vector per error kind
   logic [LANES-1:0] hit_disp;
   logic [LANES-1:0] hit_nit;
   logic [LANES-1:0] hit_ucc;
   logic [2:0]       any_hit;
   logic             mismatch;

   ////////////////////////////////////////////////////////////////////////////
   // One counter block per lane
   generate
      for (genvar l = 0; l < LANES; l++) begin : g_lane
         slem_pkg::slem_lane_err_t hit;

         slem_lane_counter u_cnt (
            .ref_clk   (ref_clk),
            .nrst      (nrst),
            .lane_en   (lane_enable_bits[l]),              // R12
            .threshold (threshold),
            .err       (lane_err[l]),
            .hit       (hit)
         );                                                // R11

         assign hit_disp[l] = hit.disp;
         assign hit_nit[l]  = hit.nit;
         assign hit_ucc[l]  = hit.ucc;
      end
   endgenerate

   // Any lane at threshold, per kind; disabled lanes already report no hit
   assign any_hit  = {|hit_disp, |hit_nit, |hit_ucc};      // R16 R17

   // Whole-field compare; a change in any byte counts as a mismatch
   assign mismatch = (rx_link_cfg != tx_link_cfg);         // R7

   ////////////////////////////////////////////////////////////////////////////
   // Register writes, flag updates and output next values
   always_comb begin
      logic [LANES-1:0] lane_wr;

      lane_wr        = reg_wdata[LANES-1:0];
      next_sync_sel  = sync_sel;
      next_cmm_en    = cmm_en;
      next_cmm_flag  = cmm_flag;
      next_threshold = threshold;
      next_irq_mask  = irq_mask;
      next_irq_flag  = irq_flag;
      next_lane_en   = lane_enable_bits;
      next_mism_q    = mismatch;

      // Writes
      if (reg_wr) begin
         case (reg_addr)
            `SLEM_ADDR_SYNC_SEL: begin
               next_sync_sel = reg_wdata[`SLEM_ERR_MSB:`SLEM_ERR_LSB];
               next_cmm_en   = reg_wdata[`SLEM_BIT_CMM_EN];
               if (reg_wdata[`SLEM_BIT_CMM_FLAG]) begin
                  next_cmm_flag = 1'b0;                    // R5
               end
            end
            `SLEM_ADDR_THRESHOLD: begin
               next_threshold = reg_wdata;                 // R9
            end
            `SLEM_ADDR_LANE_EN: begin
               next_lane_en = lane_wr;                     // R12 R13
            end
            `SLEM_ADDR_IRQ_VECTOR: begin
               next_irq_mask = reg_wdata[`SLEM_ERR_MSB:`SLEM_ERR_LSB];
            end
            default: begin
            end
         endcase
      end

      // Error flags clear on a read; a hit in the same cycle sets them again
      if (reg_rd && reg_addr == `SLEM_ADDR_IRQ_VECTOR) begin
         next_irq_flag = 3'h0;
      end
      next_irq_flag = next_irq_flag | any_hit;             // R16

      // Mismatch latches on the rising edge only, and only when enabled
      if (next_cmm_en && mismatch && !mism_q) begin
         next_cmm_flag = 1'b1;                             // R4
      end
      if (!next_cmm_en) begin
         next_cmm_flag = 1'b0;                             // R6
      end

      // Interrupt low while a masked-in flag or enabled mismatch stands
      next_irq_n = !(|(next_irq_flag & next_irq_mask)      // R10 R15
                     || (next_cmm_flag && next_cmm_en));   // R4 R6

      // Sync request follows the live hits of the selected kinds
      next_sync = |(any_hit & sync_sel);                   // R1 R2 R3 R10
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data, valid only in the cycle after the read strobe
   always_comb begin
      logic [7:0] lanes8;
      logic [7:0] reg8;

      lanes8     = 8'h00;
      reg8       = 8'h00;
      next_rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            `SLEM_ADDR_LANE_DISP: begin
               lanes8[LANES-1:0] = hit_disp;               // R16
               next_rdata        = lanes8;
            end
            `SLEM_ADDR_LANE_NIT: begin
               lanes8[LANES-1:0] = hit_nit;                // R16
               next_rdata        = lanes8;
            end
            `SLEM_ADDR_LANE_UCC: begin
               lanes8[LANES-1:0] = hit_ucc;                // R16
               next_rdata        = lanes8;
            end
            `SLEM_ADDR_IRQ_VECTOR: begin
               reg8[`SLEM_ERR_MSB:`SLEM_ERR_LSB] = irq_flag;
               next_rdata                        = reg8;
            end
            `SLEM_ADDR_SYNC_SEL: begin
               reg8[`SLEM_ERR_MSB:`SLEM_ERR_LSB] = sync_sel;
               reg8[`SLEM_BIT_CMM_FLAG]          = cmm_flag;
               reg8[`SLEM_BIT_CMM_EN]            = cmm_en;
               next_rdata                        = reg8;
            end
            `SLEM_ADDR_THRESHOLD: begin
               next_rdata = threshold;
            end
            `SLEM_ADDR_LANE_EN: begin
               lanes8[LANES-1:0] = lane_enable_bits;
               next_rdata        = lanes8;
            end
            default: begin
               next_rdata = 8'h00;                         // Unmapped reads as zero
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State registers; mism_q resets to zero, so a mismatch present at
   // release is taken as a rising edge and latched when enabled
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sync_sel         <= `SLEM_RST_SYNC_SEL;           // R14
         cmm_en           <= `SLEM_RST_CMM_EN;             // R8
         cmm_flag         <= 1'b0;
         threshold        <= `SLEM_RST_THRESHOLD;
         irq_mask         <= `SLEM_RST_IRQ_MASK;
         irq_flag         <= 3'h0;
         lane_enable_bits <= LANES'(`SLEM_RST_LANE_EN);
         mism_q           <= 1'b0;
         irq_n            <= 1'b1;
         sync_request_out <= 1'b0;
         reg_rdata        <= 8'h00;
      end else begin
         sync_sel         <= next_sync_sel;
         cmm_en           <= next_cmm_en;
         cmm_flag         <= next_cmm_flag;
         threshold        <= next_threshold;
         irq_mask         <= next_irq_mask;
         irq_flag         <= next_irq_flag;
         lane_enable_bits <= next_lane_en;
         mism_q           <= next_mism_q;
         irq_n            <= next_irq_n;
         sync_request_out <= next_sync;
         reg_rdata        <= next_rdata;
      end
   end

endmodule // slem_error_monitor

`default_nettype wire

// ===== verilog/slem_lane_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "slem_params.svh"

module slem_lane_counter (
   // Clock and reset
   input  wire logic                    ref_clk,
   input  wire logic                    nrst,
   // Control
   input  wire logic                    lane_en,
   input  wire logic [7:0]              threshold,
   // Error events and threshold hits
   input  wire slem_pkg::slem_lane_err_t err,
   output var slem_pkg::slem_lane_err_t  hit
);

   logic [7:0] cnt      [slem_pkg::SLEM_KINDS];
   logic [7:0] next_cnt [slem_pkg::SLEM_KINDS];
   logic [2:0] err_v;
   logic [2:0] hit_v;

   ////////////////////////////////////////////////////////////////////////////
   // Saturating counters; a disabled lane is held at zero so a later enable
   // starts from a clean count
   always_comb begin
      err_v = err;
      for (int i = 0; i < slem_pkg::SLEM_KINDS; i++) begin
         next_cnt[i] = cnt[i];
         if (!lane_en) begin
            next_cnt[i] = 8'h00;                           // R17
         end else if (err_v[i] && cnt[i] != `SLEM_CNT_MAX) begin
            next_cnt[i] = cnt[i] + 8'h01;                  // R9 R11
         end
         hit_v[i] = lane_en && (cnt[i] >= threshold);      // R9 R17
      end
      hit = hit_v;
   end

   // Counter registers
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < slem_pkg::SLEM_KINDS; i++) begin
            cnt[i] <= 8'h00;
         end
      end else begin
         for (int i = 0; i < slem_pkg::SLEM_KINDS; i++) begin
            cnt[i] <= next_cnt[i];
         end
      end
   end

endmodule // slem_lane_counter

`default_nettype wire

// ===== verilog/slem_params.svh
`ifndef SLEM_PARAMS_SVH
`define SLEM_PARAMS_SVH

// Register offsets, byte addressed on the plain register port
`define SLEM_ADDR_W           12
`define SLEM_ADDR_LANE_DISP   12'h46d
`define SLEM_ADDR_LANE_NIT    12'h46e
`define SLEM_ADDR_LANE_UCC    12'h46f
`define SLEM_ADDR_IRQ_VECTOR  12'h47a
`define SLEM_ADDR_SYNC_SEL    12'h47b
`define SLEM_ADDR_THRESHOLD   12'h47c
`define SLEM_ADDR_LANE_EN     12'h47d

// Field positions inside the 8-bit registers
`define SLEM_ERR_MSB          7
`define SLEM_ERR_LSB          5
`define SLEM_BIT_CMM_FLAG     4
`define SLEM_BIT_CMM_EN       3

// Reset values
`define SLEM_RST_SYNC_SEL     3'h0
`define SLEM_RST_CMM_EN       1'b1
`define SLEM_RST_IRQ_MASK     3'h0
`define SLEM_RST_THRESHOLD    8'hff
`define SLEM_RST_LANE_EN      8'hff

// Counter limits
`define SLEM_CNT_MAX          8'hff

// Link configuration compared against the local transmit settings
`define SLEM_CFG_BYTES        14

`endif

// ===== verilog/slem_pkg.sv
`default_nettype none
package slem_pkg;

   // One error event pulse of each kind for a lane; disparity is the MSB
   typedef struct packed {
      logic disp;
      logic nit;
      logic ucc;
   } slem_lane_err_t;

   // Number of error kinds carried in slem_lane_err_t
   localparam int SLEM_KINDS = 3;

endpackage

`default_nettype wire
